//--- src/dpfm_clk_div.sv
// Purpose: Even divider of aclk giving a square clock level.
// Assumes: DIV is even and at least two.
// Notes: Output is a register, low out of reset.
`timescale 1ns/100ps
module dpfm_clk_div #(
  parameter int DIV = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  output logic clk_out
);
  localparam int HALF = DIV / 2;
  localparam int CW = (HALF > 1) ? $clog2(HALF) : 1;
  localparam logic [CW-1:0] LAST = CW'(HALF - 1);
  logic [CW-1:0] cnt_q;

  if (DIV < 2 || (DIV % 2) != 0) begin : g_chk
    $error("dpfm_clk_div: DIV must be even and at least 2");
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= '0;
      clk_out <= 1'b0;
    end else if (cnt_q == LAST) begin
      cnt_q <= '0;
      clk_out <= ~clk_out;
    end else begin
      cnt_q <= cnt_q + CW'(1);
    end
  end
endmodule : dpfm_clk_div

//--- src/dpfm_map.svh
// Purpose: Register offsets, field positions, reset values and counts of the pin-function mux.
// Assumes: Byte addresses on a 32-bit AXI4-Lite bus, one aligned word per register.
// Notes: Definitions only.
`ifndef DPFM_MAP_SVH
`define DPFM_MAP_SVH

`define DPFM_ADDR_W 8
`define DPFM_REG_GPIO_EN 8'h00
`define DPFM_REG_GPIO_DIR 8'h04
`define DPFM_REG_GPIO_OUT 8'h08
`define DPFM_REG_GPIO_IN 8'h0C
`define DPFM_REG_STRAP 8'h10
`define DPFM_REG_NMI 8'h14

`define DPFM_GPIO_EN_RST 16'h0000
`define DPFM_GPIO_DIR_RST 16'h0000
`define DPFM_GPIO_OUT_RST 16'h0000
`define DPFM_EMU_RST 2'h3

`define DPFM_ST_PCI 0
`define DPFM_ST_CELL 1
`define DPFM_ST_SER2 2
`define DPFM_ST_CMUL 3
`define DPFM_ST_EMU 5
`define DPFM_ST_DONE 7
`define DPFM_ST_EMU_RSVD 8
`define DPFM_NMI_FLAG 0

`define DPFM_PIN_QCLK 1
`define DPFM_PIN_SCLK 2
`define DPFM_PIN_S2CLK 8
`define DPFM_PIN_UPPER_LO 9
`define DPFM_QUARTER_DIV 4
`define DPFM_SIXTH_DIV 6
`define DPFM_STRAP_SETTLE 3'h5

`define DPFM_RESP_OKAY 2'h0
`define DPFM_RESP_SLVERR 2'h2

`endif

//--- src/dpfm_pin_mux.sv
// Purpose: Shared-pin function mux with strap capture and AXI4-Lite control.
// Assumes: Single clock aclk at 125 MHz; peripheral-side signals are on aclk.
// Notes: Every output is registered, so pin drive lags its cause by one cycle.
//
// Implementation choices: the address map and register access over AXI4-Lite.
`timescale 1ns/100ps
`include "dpfm_map.svh"

module dpfm_pin_mux #(
  parameter int HPW = 32,
  parameter int SCW = 8,
  parameter int PSW = 2,
  parameter int CSW = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`DPFM_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`DPFM_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic pci_select_strap,
  input wire logic cell_port_select_strap,
  input wire logic serial2_select_strap,
  input wire logic [1:0] clock_multiplier_strap,
  input wire logic [1:0] emulation_mode_pins,
  input wire logic nmi_pin,
  input wire logic [15:0] gpio_pin_in,
  output logic [15:0] gpio_pin_out,
  output logic [15:0] gpio_pin_oe,
  input wire logic [6:0] pci_upper_out,
  input wire logic [6:0] pci_upper_oe,
  output logic [6:0] pci_upper_in,
  output logic serial2_ext_clock_in,
  input wire logic [HPW-1:0] hp_pin_in,
  output logic [HPW-1:0] hp_pin_out,
  output logic [HPW-1:0] hp_pin_oe,
  input wire logic [HPW-1:0] host_port_out,
  input wire logic [HPW-1:0] host_port_oe,
  output logic [HPW-1:0] host_port_in,
  input wire logic [HPW-1:0] pci_hp_out,
  input wire logic [HPW-1:0] pci_hp_oe,
  output logic [HPW-1:0] pci_hp_in,
  input wire logic [SCW-1:0] sc_pin_in,
  output logic [SCW-1:0] sc_pin_out,
  output logic [SCW-1:0] sc_pin_oe,
  input wire logic [SCW-1:0] serial_port_one_out,
  input wire logic [SCW-1:0] serial_port_one_oe,
  output logic [SCW-1:0] serial_port_one_in,
  input wire logic [SCW-1:0] cell_sc_out,
  input wire logic [SCW-1:0] cell_sc_oe,
  output logic [SCW-1:0] cell_sc_in,
  input wire logic [PSW-1:0] pci_solo_out,
  input wire logic [PSW-1:0] pci_solo_oe,
  output logic [PSW-1:0] pci_solo_pin_out,
  output logic [PSW-1:0] pci_solo_pin_oe,
  input wire logic [CSW-1:0] cell_solo_out,
  input wire logic [CSW-1:0] cell_solo_oe,
  output logic [CSW-1:0] cell_solo_pin_out,
  output logic [CSW-1:0] cell_solo_pin_oe,
  output logic host_port_enable,
  output logic pci_enable,
  output logic serial_port_one_enable,
  output logic cell_port_enable,
  output logic serial2_enable,
  output logic pci_eeprom_enable,
  output logic [3:0] core_clock_factor,
  output logic boundary_scan_mode,
  output logic emulation_mode,
  output logic nmi_event
);
  import dpfm_pkg::*;

  localparam int SYW = 16 + HPW + SCW + 8;

  if (HPW < 1 || SCW < 1 || PSW < 1 || CSW < 1) begin : g_chk
    $error("dpfm_pin_mux: pin group widths must be at least 1");
  end

  // Pin inputs, synchronised and filtered
  logic [SYW-1:0] sy_in;
  logic [SYW-1:0] sy_out;
  logic [15:0] gp_s;
  logic [HPW-1:0] hp_s;
  logic [SCW-1:0] sc_s;
  logic pci_s;
  logic cell_s;
  logic ser2_s;
  logic [1:0] cmul_s;
  logic [1:0] emu_s;
  logic nmi_s;

  assign sy_in = {gpio_pin_in, hp_pin_in, sc_pin_in, pci_select_strap, cell_port_select_strap,
                  serial2_select_strap, clock_multiplier_strap, emulation_mode_pins, nmi_pin};
  assign {gp_s, hp_s, sc_s, pci_s, cell_s, ser2_s, cmul_s, emu_s, nmi_s} = sy_out;

  dpfm_sync3 #(.W(SYW)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(sy_in),
    .q(sy_out)
  );

  logic qclk;
  logic sclk;

  dpfm_clk_div #(.DIV(`DPFM_QUARTER_DIV)) u_qdiv (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_out(qclk)
  );
  dpfm_clk_div #(.DIV(`DPFM_SIXTH_DIV)) u_sdiv (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_out(sclk)
  );

  // Strap capture; the filter needs a few cycles before its output is trusted
  dpfm_cap_t cap_q;
  logic [2:0] settle_q;
  logic pci_q;
  logic cell_q;
  logic ser2_q;
  logic [1:0] cmul_q;
  logic [1:0] emu_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cap_q <= DPFM_CAP_SETTLE;
      settle_q <= 3'h0;
      pci_q <= 1'b0;
      cell_q <= 1'b0;
      ser2_q <= 1'b0;
      cmul_q <= 2'h0;
      emu_q <= `DPFM_EMU_RST;
    end else begin
      case (cap_q)
        DPFM_CAP_SETTLE: begin
          settle_q <= settle_q + 3'h1;
          if (settle_q == `DPFM_STRAP_SETTLE) begin
            cap_q <= DPFM_CAP_HELD;
            pci_q <= pci_s;
            cell_q <= cell_s;
            ser2_q <= ser2_s;
            cmul_q <= cmul_s;
            emu_q <= emu_s;
          end
        end
        DPFM_CAP_HELD: cap_q <= DPFM_CAP_HELD;
        default: cap_q <= DPFM_CAP_SETTLE;
      endcase
    end
  end

  // Software registers
  logic [15:0] gp_en_q;
  logic [15:0] gp_dir_q;
  logic [15:0] gp_out_q;
  logic nmi_flag_q;
  logic nmi_prev_q;
  logic aw_held_q;
  logic w_held_q;
  logic [`DPFM_ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;

  function automatic logic [15:0] dpfm_merge(input logic [15:0] old, input logic [31:0] data,
                                             input logic [3:0] strb);
    logic [15:0] res;
    res = old;
    if (strb[0]) res[7:0] = data[7:0];
    if (strb[1]) res[15:8] = data[15:8];
    return res;
  endfunction : dpfm_merge

  wire aw_hs = s_axi_awvalid && s_axi_awready;
  wire w_hs = s_axi_wvalid && s_axi_wready;
  wire b_hs = s_axi_bvalid && s_axi_bready;
  wire ar_hs = s_axi_arvalid && s_axi_arready;
  wire r_hs = s_axi_rvalid && s_axi_rready;
  wire do_write = aw_held_q && w_held_q && !s_axi_bvalid;
  wire wr_en = do_write && (awaddr_q == `DPFM_REG_GPIO_EN);
  wire wr_dir = do_write && (awaddr_q == `DPFM_REG_GPIO_DIR);
  wire wr_out = do_write && (awaddr_q == `DPFM_REG_GPIO_OUT);
  wire wr_nmi = do_write && (awaddr_q == `DPFM_REG_NMI);
  wire wr_ro = do_write && ((awaddr_q == `DPFM_REG_GPIO_IN) || (awaddr_q == `DPFM_REG_STRAP));
  wire wr_ok = wr_en || wr_dir || wr_out || wr_nmi || wr_ro;
  wire nmi_rise = nmi_s && !nmi_prev_q;
  wire nmi_clr = wr_nmi && wstrb_q[0] && wdata_q[`DPFM_NMI_FLAG];

  // Write channel: address and data taken in either order, one write at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `DPFM_RESP_OKAY;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else begin
      if (aw_hs) begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (do_write) begin
        aw_held_q <= 1'b0;
      end else if (b_hs) begin
        s_axi_awready <= 1'b1;
      end
      if (w_hs) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (do_write) begin
        w_held_q <= 1'b0;
      end else if (b_hs) begin
        s_axi_wready <= 1'b1;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `DPFM_RESP_OKAY : `DPFM_RESP_SLVERR;
      end else if (b_hs) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gp_en_q <= `DPFM_GPIO_EN_RST;
      gp_dir_q <= `DPFM_GPIO_DIR_RST;
      gp_out_q <= `DPFM_GPIO_OUT_RST;
      nmi_flag_q <= 1'b0;
      nmi_prev_q <= 1'b0;
    end else begin
      if (wr_en) gp_en_q <= dpfm_merge(gp_en_q, wdata_q, wstrb_q);
      if (wr_dir) gp_dir_q <= dpfm_merge(gp_dir_q, wdata_q, wstrb_q);
      if (wr_out) gp_out_q <= dpfm_merge(gp_out_q, wdata_q, wstrb_q);
      nmi_prev_q <= nmi_s;
      // A new edge wins over a clear in the same cycle
      nmi_flag_q <= nmi_rise | (nmi_flag_q & ~nmi_clr);
    end
  end

  // Read channel
  wire [`DPFM_ADDR_W-1:0] ra = s_axi_araddr;
  wire emu_rsvd = (emu_q == DPFM_EMU_RSVD1) || (emu_q == DPFM_EMU_RSVD2);
  wire [31:0] strap_word = {23'h0, emu_rsvd, (cap_q == DPFM_CAP_HELD), emu_q, cmul_q,
                            ser2_q, cell_q, pci_q};
  wire rd_hit = (ra == `DPFM_REG_GPIO_EN) || (ra == `DPFM_REG_GPIO_DIR)
             || (ra == `DPFM_REG_GPIO_OUT) || (ra == `DPFM_REG_GPIO_IN)
             || (ra == `DPFM_REG_STRAP) || (ra == `DPFM_REG_NMI);
  wire [31:0] rd_word = (ra == `DPFM_REG_GPIO_EN) ? {16'h0, gp_en_q}
                      : (ra == `DPFM_REG_GPIO_DIR) ? {16'h0, gp_dir_q}
                      : (ra == `DPFM_REG_GPIO_OUT) ? {16'h0, gp_out_q}
                      : (ra == `DPFM_REG_GPIO_IN) ? {16'h0, gp_s}
                      : (ra == `DPFM_REG_STRAP) ? strap_word
                      : (ra == `DPFM_REG_NMI) ? {31'h0, nmi_flag_q}
                      : 32'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `DPFM_RESP_OKAY;
    end else if (ar_hs) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? `DPFM_RESP_OKAY : `DPFM_RESP_SLVERR;
    end else if (r_hs) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
    end
  end

  // Software-configured pins
  logic [15:0] gp_out_d;
  logic [15:0] gp_oe_d;
  logic [6:0] pci_up_in_d;

  for (genvar i = 0; i < 16; i++) begin : g_pin
    wire gp_drv = gp_en_q[i] && gp_dir_q[i];
    if (i >= `DPFM_PIN_UPPER_LO) begin : g_up
      assign gp_out_d[i] = pci_q ? pci_upper_out[i-`DPFM_PIN_UPPER_LO] : gp_out_q[i];
      assign gp_oe_d[i] = pci_q ? pci_upper_oe[i-`DPFM_PIN_UPPER_LO] : gp_drv;
      assign pci_up_in_d[i-`DPFM_PIN_UPPER_LO] = pci_q & gp_s[i];
    end else if (i == `DPFM_PIN_QCLK) begin : g_q
      assign gp_out_d[i] = gp_en_q[i] ? gp_out_q[i] : qclk;
      assign gp_oe_d[i] = gp_en_q[i] ? gp_drv : 1'b1;
    end else if (i == `DPFM_PIN_SCLK) begin : g_s
      assign gp_out_d[i] = gp_en_q[i] ? gp_out_q[i] : sclk;
      assign gp_oe_d[i] = gp_en_q[i] ? gp_drv : 1'b1;
    end else begin : g_plain
      assign gp_out_d[i] = gp_out_q[i];
      assign gp_oe_d[i] = gp_drv;
    end
  end

  // Strap-owned groups; the deselected side sees zero
  wire ser2_en_d = !(pci_q && !ser2_q);
  wire [3:0] factor_d = (cmul_q == DPFM_CMUL_BYPASS) ? 4'h1
                      : (cmul_q == DPFM_CMUL_X6) ? 4'h6
                      : (cmul_q == DPFM_CMUL_X12) ? 4'hC : 4'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gpio_pin_out <= '0;
      gpio_pin_oe <= '0;
      pci_upper_in <= '0;
      serial2_ext_clock_in <= 1'b0;
      hp_pin_out <= '0;
      hp_pin_oe <= '0;
      host_port_in <= '0;
      pci_hp_in <= '0;
      sc_pin_out <= '0;
      sc_pin_oe <= '0;
      serial_port_one_in <= '0;
      cell_sc_in <= '0;
      pci_solo_pin_out <= '0;
      pci_solo_pin_oe <= '0;
      cell_solo_pin_out <= '0;
      cell_solo_pin_oe <= '0;
      host_port_enable <= 1'b0;
      pci_enable <= 1'b0;
      serial_port_one_enable <= 1'b0;
      cell_port_enable <= 1'b0;
      serial2_enable <= 1'b0;
      pci_eeprom_enable <= 1'b0;
      core_clock_factor <= 4'h0;
      boundary_scan_mode <= 1'b0;
      emulation_mode <= 1'b0;
      nmi_event <= 1'b0;
    end else begin
      gpio_pin_out <= gp_out_d;
      gpio_pin_oe <= gp_oe_d;
      pci_upper_in <= pci_up_in_d;
      serial2_ext_clock_in <= !gp_en_q[`DPFM_PIN_S2CLK] && gp_s[`DPFM_PIN_S2CLK];
      hp_pin_out <= pci_q ? pci_hp_out : host_port_out;
      hp_pin_oe <= pci_q ? pci_hp_oe : host_port_oe;
      host_port_in <= pci_q ? '0 : hp_s;
      pci_hp_in <= pci_q ? hp_s : '0;
      sc_pin_out <= cell_q ? cell_sc_out : serial_port_one_out;
      sc_pin_oe <= cell_q ? cell_sc_oe : serial_port_one_oe;
      serial_port_one_in <= cell_q ? '0 : sc_s;
      cell_sc_in <= cell_q ? sc_s : '0;
      pci_solo_pin_out <= pci_q ? pci_solo_out : '0;
      pci_solo_pin_oe <= pci_q ? pci_solo_oe : '0;
      cell_solo_pin_out <= cell_q ? cell_solo_out : '0;
      cell_solo_pin_oe <= cell_q ? cell_solo_oe : '0;
      host_port_enable <= !pci_q;
      pci_enable <= pci_q;
      serial_port_one_enable <= !cell_q;
      cell_port_enable <= cell_q;
      serial2_enable <= ser2_en_d;
      pci_eeprom_enable <= !ser2_en_d;
      core_clock_factor <= factor_d;
      boundary_scan_mode <= (emu_q == DPFM_EMU_SCAN);
      emulation_mode <= (emu_q == DPFM_EMU_NORMAL);
      nmi_event <= nmi_rise;
    end
  end
endmodule : dpfm_pin_mux

//--- src/dpfm_pkg.sv
// Purpose: Types shared by the pin-function mux files.
// Assumes: Constants live in dpfm_map.svh.
// Notes: Codes are written out; only the capture states are one-hot.
package dpfm_pkg;

  typedef enum logic [1:0] {
    DPFM_CAP_SETTLE = 2'h1,
    DPFM_CAP_HELD = 2'h2
  } dpfm_cap_t;

  typedef enum logic [1:0] {
    DPFM_CMUL_BYPASS = 2'h0,
    DPFM_CMUL_X6 = 2'h1,
    DPFM_CMUL_X12 = 2'h2,
    DPFM_CMUL_RSVD = 2'h3
  } dpfm_cmul_t;

  typedef enum logic [1:0] {
    DPFM_EMU_SCAN = 2'h0,
    DPFM_EMU_RSVD1 = 2'h1,
    DPFM_EMU_RSVD2 = 2'h2,
    DPFM_EMU_NORMAL = 2'h3
  } dpfm_emu_t;

endpackage : dpfm_pkg

//--- src/dpfm_sync3.sv
// Purpose: Three-stage pin synchroniser with agreement filter.
// Assumes: Inputs are asynchronous to aclk.
// Notes: Output follows only when stages two and three agree.
`timescale 1ns/100ps
module dpfm_sync3 #(
  parameter int W = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] agree;

  if (W < 1) begin : g_chk
    $error("dpfm_sync3: W must be at least 1");
  end

  // First stage feeds only the second
  assign agree = ~(s2_q ^ s3_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      q <= '0;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      q <= (agree & s3_q) | (~agree & q);
    end
  end
endmodule : dpfm_sync3

//--- tb/dpfm_board.sv
// Purpose: Board model: strap resistors and the external buses facing the mux.
// Assumes: Straps are set by the bench through cfg.
// Notes: Bus values walk every cycle so a stale value never passes for a fresh one.
`timescale 1ns/100ps
module dpfm_board (
  input wire logic aclk,
  input wire logic [6:0] cfg,
  output logic pci_select_strap,
  output logic cell_port_select_strap,
  output logic serial2_select_strap,
  output logic [1:0] clock_multiplier_strap,
  output logic [1:0] emulation_mode_pins,
  output logic [31:0] bus_q
);
  // steady strap levels
  // Resistor levels: driven through reset, never floated
  assign pci_select_strap = cfg[0];
  assign cell_port_select_strap = cfg[1];
  assign serial2_select_strap = cfg[2];
  assign clock_multiplier_strap = cfg[4:3];
  assign emulation_mode_pins = cfg[6:5];
  initial bus_q = 32'h0;
  always @(posedge aclk) begin
    bus_q <= {bus_q[30:0], ~bus_q[31]};
  end
endmodule : dpfm_board

//--- tb/dpfm_pin_mux_checker.sv
// Purpose: Port-level checks of the pin-function mux.
// Assumes: Bound to dpfm_pin_mux; registered outputs lag their cause by one edge.
// Notes: Strap-driven checks other than the three exclusion checks wait until the capture has surely settled.
`timescale 1ns/100ps
module dpfm_pin_mux_checker #(
  parameter int HPW = 32,
  parameter int SCW = 8,
  parameter int PSW = 2,
  parameter int CSW = 8
) (
  input logic aclk,
  input logic aresetn,
  input logic nmi_pin,
  input logic [15:0] gpio_pin_oe,
  input logic [6:0] pci_upper_oe,
  input logic [HPW-1:0] hp_pin_oe,
  input logic [HPW-1:0] host_port_oe,
  input logic [SCW-1:0] sc_pin_oe,
  input logic [SCW-1:0] cell_sc_oe,
  input logic [PSW-1:0] pci_solo_pin_oe,
  input logic [CSW-1:0] cell_solo_pin_oe,
  input logic host_port_enable,
  input logic pci_enable,
  input logic serial_port_one_enable,
  input logic cell_port_enable,
  input logic serial2_enable,
  input logic [3:0] core_clock_factor,
  input logic boundary_scan_mode,
  input logic emulation_mode,
  input logic nmi_event
);
  logic [3:0] up_q;
  logic [3:0] up_d;
  logic settled;
  // Saturating count of edges since release; capture is final long before 15
  assign settled = (up_q == 4'hF);
  assign up_d = settled ? up_q : up_q + 4'h1;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      up_q <= 4'h0;
    end else begin
      up_q <= up_d;
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_host_pci_excl: assert property (pci_enable |-> !host_port_enable)
    else $error("host port and PCI enabled together");
  a_ser_cell_excl: assert property (cell_port_enable |-> !serial_port_one_enable)
    else $error("serial port one and cell port enabled together");
  a_straps_fixed: assert property (settled |-> $stable({pci_enable, cell_port_enable,
    serial2_enable, core_clock_factor})) else $error("strap selection moved after capture");
  a_ser2_off_pci: assert property (settled && !serial2_enable |-> pci_enable)
    else $error("serial port two off without PCI strap");
  a_pci_solo_z: assert property (settled && !pci_enable |-> pci_solo_pin_oe == '0)
    else $error("stand-alone PCI pins driven while deselected");
  a_cell_solo_z: assert property (settled && !cell_port_enable |-> cell_solo_pin_oe == '0)
    else $error("stand-alone cell pins driven while deselected");
  a_hp_host_own: assert property (settled && host_port_enable |=>
    hp_pin_oe == $past(host_port_oe)) else $error("shared host pins not driven by host port");
  a_sc_cell_own: assert property (settled && cell_port_enable |=>
    sc_pin_oe == $past(cell_sc_oe)) else $error("shared serial pins not driven by cell port");
  a_upper_pci_own: assert property (settled && pci_enable |=>
    gpio_pin_oe[15:9] == $past(pci_upper_oe)) else $error("upper GPIO pins not PCI-owned");
  a_emu_exclusive: assert property (!(boundary_scan_mode && emulation_mode))
    else $error("scan and emulation mode both set");
  a_factor_legal: assert property (settled |-> core_clock_factor inside
    {4'h0, 4'h1, 4'h6, 4'hC}) else $error("illegal core clock factor");
  a_nmi_one_shot: assert property (nmi_event |=> !nmi_event)
    else $error("nmi event wider than one cycle");
  a_nmi_no_level: assert property (nmi_pin [*8] ##1 nmi_pin |-> !nmi_event)
    else $error("nmi event from a steady high level");
  c_pci: cover property (settled && pci_enable);
  c_cell: cover property (settled && cell_port_enable);
  c_scan: cover property (settled && boundary_scan_mode);
  c_nmi: cover property (nmi_event);
endmodule : dpfm_pin_mux_checker

//--- tb/dpfm_pin_mux_tb.sv
// Purpose: Self-checking bench of the pin-function mux.
// Assumes: AXI4-Lite master tasks; straps and peripheral buses from dpfm_board.
// Notes: Pin outputs are sampled on the falling edge; AXI responses are sampled on the rising edge.
`timescale 1ns/100ps
`include "dpfm_map.svh"
module dpfm_pin_mux_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, bus_q;
  logic [3:0] s_axi_wstrb, core_clock_factor;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, clock_multiplier_strap, emulation_mode_pins, md_v;
  logic pci_select_strap, cell_port_select_strap, serial2_select_strap, nmi_pin, nmi_event;
  logic [15:0] gpio_pin_out, gpio_pin_oe;
  logic [5:0] en_v;
  logic [6:0] cfg;
  logic [6:0] tbl [4] = '{7'h60, 7'h13, 7'h6E, 7'h3D};
  int fail_count = 0;
  int n_compared = 0;
  always #4 aclk = ~aclk;
  dpfm_board dpfm_board_i (.aclk, .cfg, .pci_select_strap, .cell_port_select_strap,
    .serial2_select_strap, .clock_multiplier_strap, .emulation_mode_pins, .bus_q);
  dpfm_pin_mux dpfm_pin_mux_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .pci_select_strap, .cell_port_select_strap,
    .serial2_select_strap, .clock_multiplier_strap, .emulation_mode_pins, .nmi_pin,
    .gpio_pin_in(bus_q[15:0]), .gpio_pin_out, .gpio_pin_oe, .pci_upper_out(bus_q[6:0]),
    .pci_upper_oe(~bus_q[7:1]), .pci_upper_in(), .serial2_ext_clock_in(), .hp_pin_in(bus_q),
    .hp_pin_out(), .hp_pin_oe(), .host_port_out(bus_q), .host_port_oe(~bus_q),
    .host_port_in(), .pci_hp_out(~bus_q), .pci_hp_oe(bus_q), .pci_hp_in(),
    .sc_pin_in(bus_q[7:0]), .sc_pin_out(), .sc_pin_oe(), .serial_port_one_out(bus_q[8:1]),
    .serial_port_one_oe(bus_q[9:2]), .serial_port_one_in(), .cell_sc_out(~bus_q[7:0]),
    .cell_sc_oe(~bus_q[9:2]), .cell_sc_in(), .pci_solo_out(bus_q[1:0]),
    .pci_solo_oe(bus_q[2:1]), .pci_solo_pin_out(), .pci_solo_pin_oe(),
    .cell_solo_out(bus_q[7:0]), .cell_solo_oe(bus_q[8:1]), .cell_solo_pin_out(),
    .cell_solo_pin_oe(), .host_port_enable(en_v[5]), .pci_enable(en_v[4]),
    .serial_port_one_enable(en_v[3]), .cell_port_enable(en_v[2]), .serial2_enable(en_v[1]),
    .pci_eeprom_enable(en_v[0]), .core_clock_factor, .boundary_scan_mode(md_v[1]),
    .emulation_mode(md_v[0]), .nmi_event);
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task wrap_up;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, r);
  endtask : axw
  task axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, d);
    chk(s_axi_rresp, r);
  endtask : axr
  // Straps are set at reset entry so they are stable well before release
  task rst(input logic [6:0] c);
    @(posedge aclk);
    cfg <= c;
    aresetn <= 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (12) @(posedge aclk);
  endtask : rst
  function logic [3:0] fac(input logic [1:0] m);
    case (m)
      2'h0: return 4'h1;
      2'h1: return 4'h6;
      2'h2: return 4'hC;
      default: return 4'h0;
    endcase
  endfunction : fac
  task t_regs;
    axr(`DPFM_REG_GPIO_EN, 32'h0, `DPFM_RESP_OKAY);
    axr(`DPFM_REG_GPIO_DIR, 32'h0, `DPFM_RESP_OKAY);
    axw(`DPFM_REG_STRAP, 32'hFFFF, `DPFM_RESP_OKAY);
    axr(`DPFM_REG_STRAP, 32'hE0, `DPFM_RESP_OKAY);
    axw(8'h40, 32'h1, `DPFM_RESP_SLVERR);
    axr(8'h40, 32'h0, `DPFM_RESP_SLVERR);
  endtask : t_regs
  task t_clk;
    int t1;
    int t2;
    logic [1:0] p;
    t1 = 0;
    t2 = 0;
    @(negedge aclk);
    p = gpio_pin_out[2:1];
    chk(gpio_pin_oe[2:1], 2'h3);
    repeat (12) begin
      @(negedge aclk);
      t1 += (gpio_pin_out[1] !== p[0]);
      t2 += (gpio_pin_out[2] !== p[1]);
      p = gpio_pin_out[2:1];
    end
    chk(t1, 6);
    chk(t2, 4);
    axw(`DPFM_REG_GPIO_EN, 32'h6, `DPFM_RESP_OKAY);
    axw(`DPFM_REG_GPIO_DIR, 32'h2, `DPFM_RESP_OKAY);
    axw(`DPFM_REG_GPIO_OUT, 32'h6, `DPFM_RESP_OKAY);
    repeat (2) @(negedge aclk);
    chk({gpio_pin_oe[2:1], gpio_pin_out[1]}, 3'h3);
    axw(`DPFM_REG_GPIO_EN, 32'h0, `DPFM_RESP_OKAY);
    repeat (2) @(negedge aclk);
    chk(gpio_pin_oe[2:1], 2'h3);
  endtask : t_clk
  task t_upper;
    axw(`DPFM_REG_GPIO_EN, 32'hFE00, `DPFM_RESP_OKAY);
    axw(`DPFM_REG_GPIO_DIR, 32'hFE00, `DPFM_RESP_OKAY);
    axw(`DPFM_REG_GPIO_OUT, 32'hA000, `DPFM_RESP_OKAY);
    repeat (2) @(negedge aclk);
    chk({gpio_pin_oe[15:9], gpio_pin_out[15:9]}, 14'h3FD0);
  endtask : t_upper
  task t_nmi;
    int n;
    n = 0;
    @(posedge aclk);
    nmi_pin <= 1'b1;
    repeat (16) begin
      @(negedge aclk);
      n += (nmi_event === 1'b1);
    end
    chk(n, 1);
    axr(`DPFM_REG_NMI, 32'h1, `DPFM_RESP_OKAY);
    axw(`DPFM_REG_NMI, 32'h1, `DPFM_RESP_OKAY);
    axr(`DPFM_REG_NMI, 32'h0, `DPFM_RESP_OKAY);
    @(posedge aclk);
    nmi_pin <= 1'b0;
    repeat (8) @(posedge aclk);
  endtask : t_nmi
  task t_straps;
    logic [6:0] c;
    logic [5:0] e;
    for (int i = 0; i < 4; i++) begin
      c = tbl[i];
      e = {~c[0], c[0], ~c[1], c[1], ~(c[0] & ~c[2]), c[0] & ~c[2]};
      rst(c);
      if (c[0]) axw(`DPFM_REG_GPIO_EN, 32'hFE00, `DPFM_RESP_OKAY);
      @(negedge aclk);
      chk(en_v, e);
      chk(core_clock_factor, fac(c[4:3]));
      chk(md_v, {c[6:5] == 2'h0, c[6:5] == 2'h3});
      axr(`DPFM_REG_STRAP, {23'h0, ^c[6:5], 1'b1, c}, `DPFM_RESP_OKAY);
      @(posedge aclk);
      cfg <= ~c;
      repeat (10) @(negedge aclk);
      chk(en_v, e);
      axr(`DPFM_REG_STRAP, {23'h0, ^c[6:5], 1'b1, c}, `DPFM_RESP_OKAY);
    end
  endtask : t_straps
  initial begin
    s_axi_awaddr = 8'h0;
    s_axi_araddr = 8'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    nmi_pin = 1'b0;
    cfg = 7'h60;
    rst(7'h60);
    t_regs;
    t_clk;
    t_upper;
    t_nmi;
    t_straps;
    wrap_up;
  end
  initial begin
    #100000;
    fail_count++;
    $display("watchdog expired");
    wrap_up;
  end
endmodule : dpfm_pin_mux_tb
bind dpfm_pin_mux dpfm_pin_mux_checker #(.HPW(HPW), .SCW(SCW), .PSW(PSW), .CSW(CSW))
  dpfm_pin_mux_checker_i (.aclk, .aresetn, .nmi_pin, .gpio_pin_oe, .pci_upper_oe, .hp_pin_oe,
  .host_port_oe, .sc_pin_oe, .cell_sc_oe, .pci_solo_pin_oe, .cell_solo_pin_oe,
  .host_port_enable, .pci_enable, .serial_port_one_enable, .cell_port_enable, .serial2_enable,
  .core_clock_factor, .boundary_scan_mode, .emulation_mode, .nmi_event);
